// ===== hw/nic_status_top.sv
// nic_status_top: reset sequencing, start gating, bus request and status indicators
// assumes network events and fifo service requests come from logic on clk_i
// What this block does
// - a low reset input enters reset at once, no waiting for activity.
// - internal reset action finishes within 10 bus-side clock cycles.
// - no transmit or receive after reset until software sets the start bit.
// - reset restores command, interrupt mask, data and transmit configuration.
// - bus request is active high, raised whenever the fifo needs service once reset sequencing is over.
// - polarity flag rests low, rises after 7 pulses or 3 packets reversed, counted only while started and factory test is low.
// - transmit indicator held high about 50 ms for each transmission.
// - collision indicator held high about 50 ms for each collision.
`timescale 1ns/1ps
module nic_status_top
  import nic_status_pkg::*;
#(
  parameter int STRETCH = nic_status_pkg::STRETCH_CYCLES
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire nic_status_pkg::cfg_write_s cfg_wr_i,
  input wire nic_status_pkg::net_events_s net_ev_i,
  input wire logic fifo_service_i,
  input wire logic bus_grant_i,
  input wire logic factory_test_i,
  output nic_status_pkg::cfg_regs_s cfg_o,
  output logic reset_done_o,
  output logic net_enable_o,
  output logic bus_request_line_o,
  output logic dma_go_o,
  output logic polarity_reversed_flag_o,
  output logic transmit_activity_indicator_o,
  output logic collision_o
);
  import nic_status_pkg::*;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic grant_s1_r, grant_s2_r, test_s1_r, test_s2_r;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      grant_s1_r <= 1'b0;
      grant_s2_r <= 1'b0;
      test_s1_r <= 1'b0;
      test_s2_r <= 1'b0;
    end else if (ce_i) begin
      grant_s1_r <= bus_grant_i;
      grant_s2_r <= grant_s1_r;
      test_s1_r <= factory_test_i;
      test_s2_r <= test_s1_r;
    end
  end

  // ****************************************
  // reset sequencing
  // ****************************************
  // asynchronous clear acts at once, regardless of traffic
  run_state_e state_r;
  logic [3:0] rst_cnt_r;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= ST_RESET;
      rst_cnt_r <= 4'h0;
      reset_done_o <= 1'b0;
    end else if (ce_i) begin
      unique case (state_r)
        ST_RESET: begin
          // internal clean-up counted out in exactly the 10-cycle bound
          if (rst_cnt_r == RESET_CNT_W_MAX) begin
            state_r <= ST_STOPPED;
            reset_done_o <= 1'b1;
          end else begin
            rst_cnt_r <= rst_cnt_r + 4'h1;
          end
        end
        ST_STOPPED: begin
          if (cfg_o.cmd[CMD_START_BIT]) state_r <= ST_RUNNING;
        end
        ST_RUNNING: begin
          if (!cfg_o.cmd[CMD_START_BIT]) state_r <= ST_STOPPED;
        end
      endcase
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  // all four return to reset values on reset
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_o <= '{cmd: CMD_RESET_VAL, imask: IMASK_RESET_VAL,
                 dcfg: DCFG_RESET_VAL, tcfg: TCFG_RESET_VAL};
    end else if (ce_i && state_r != ST_RESET) begin
      if (cfg_wr_i.cmd_we) cfg_o.cmd <= cfg_wr_i.wdata;
      if (cfg_wr_i.imask_we) cfg_o.imask <= cfg_wr_i.wdata;
      if (cfg_wr_i.dcfg_we) cfg_o.dcfg <= cfg_wr_i.wdata;
      if (cfg_wr_i.tcfg_we) cfg_o.tcfg <= cfg_wr_i.wdata;
    end
  end

  // network traffic gated off unless started, and held off while factory test is up
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) net_enable_o <= 1'b0;
    else if (ce_i) net_enable_o <= (state_r == ST_RUNNING) && !test_s2_r;
  end
  wire net_on = (state_r == ST_RUNNING) && !test_s2_r;

  // ****************************************
  // bus request and grant
  // ****************************************
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bus_request_line_o <= 1'b0;
      dma_go_o <= 1'b0;
    end else if (ce_i) begin
      bus_request_line_o <= fifo_service_i && state_r != ST_RESET;
      // dma only with request up and grant seen
      dma_go_o <= bus_request_line_o && grant_s2_r && fifo_service_i;
    end
  end

  // ****************************************
  // polarity detection
  // ****************************************
  logic [2:0] pulse_run_r;
  logic [1:0] pkt_run_r;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pulse_run_r <= 3'h0;
      pkt_run_r <= 2'h0;
      polarity_reversed_flag_o <= 1'b0;
    end else if (ce_i && net_on) begin
      if (net_ev_i.link_pulse) begin
        if (!net_ev_i.link_pulse_reversed) pulse_run_r <= 3'h0;
        else if (pulse_run_r != 3'(LINK_PULSE_RUN)) pulse_run_r <= pulse_run_r + 3'h1;
      end
      if (net_ev_i.packet_rx) begin
        if (!net_ev_i.packet_reversed) pkt_run_r <= 2'h0;
        else if (pkt_run_r != 2'(PACKET_RUN)) pkt_run_r <= pkt_run_r + 2'h1;
      end
      // the counters saturate so the flag stays up while reversal persists
      polarity_reversed_flag_o <= (pulse_run_r == 3'(LINK_PULSE_RUN))
                                  || (pkt_run_r == 2'(PACKET_RUN));
    end
  end

  // ****************************************
  // activity indicators
  // ****************************************
  pulse_stretch #(.STRETCH(STRETCH)) u_tx_led (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .en_i(ce_i),
    .trig_i(net_ev_i.tx_active && net_on),
    .out_o(transmit_activity_indicator_o)
  );
  pulse_stretch #(.STRETCH(STRETCH)) u_col_led (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .en_i(ce_i),
    .trig_i(net_ev_i.collision && net_on),
    .out_o(collision_o)
  );

  // ****************************************
  // checks
  // ****************************************
  localparam int RESET_BOUND = RESET_DONE_CYCLES;
  property p_reset_done;
    @(posedge clk_i) disable iff (!nrst_i)
      (state_r == ST_RESET && rst_cnt_r == 4'h0 && ce_i) |-> ##[1:RESET_BOUND] reset_done_o;
  endproperty
  a_reset_done: assert property (p_reset_done) else $error("reset not done");

  property p_no_net_before_start;
    @(posedge clk_i) disable iff (!nrst_i)
      // enable lags the start bit by two edges: register, then state, then output
      net_enable_o |-> $past(cfg_o.cmd[CMD_START_BIT], 2);
  endproperty
  a_no_net_before_start: assert property (p_no_net_before_start)
    else $error("net enabled without start");

  property p_bus_req;
    @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && fifo_service_i && reset_done_o) |=> bus_request_line_o;
  endproperty
  a_bus_req: assert property (p_bus_req) else $error("bus request missing");

  property p_grant;
    @(posedge clk_i) disable iff (!nrst_i)
      dma_go_o |-> $past(grant_s2_r);
  endproperty
  a_grant: assert property (p_grant) else $error("dma without grant");

  property p_polarity;
    @(posedge clk_i) disable iff (!nrst_i)
      $rose(polarity_reversed_flag_o) |->
        $past(pulse_run_r) == 3'(LINK_PULSE_RUN) || $past(pkt_run_r) == 2'(PACKET_RUN);
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity without cause");

  property p_tx;
    @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && net_on && net_ev_i.tx_active) |=> transmit_activity_indicator_o;
  endproperty
  a_tx: assert property (p_tx) else $error("tx indicator missing");

  property p_col;
    @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && net_on && net_ev_i.collision) |=> collision_o [*2];
  endproperty
  a_col: assert property (p_col) else $error("collision indicator short");

  property p_test;
    @(posedge clk_i) disable iff (!nrst_i)
      test_s2_r |=> !net_enable_o;
  endproperty
  a_test: assert property (p_test) else $error("net on in test mode");

  property p_cfg_reset;
    @(posedge clk_i) disable iff (!nrst_i)
      (state_r == ST_RESET) |-> cfg_o.cmd == CMD_RESET_VAL && cfg_o.imask == IMASK_RESET_VAL
        && cfg_o.dcfg == DCFG_RESET_VAL && cfg_o.tcfg == TCFG_RESET_VAL;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset) else $error("cfg not at reset");
endmodule

// ===== hw/nic_status_pkg.sv
// nic_status_pkg: constants and carriers for the reset and status indicator block
// assumes a single 125 MHz clock domain
package nic_status_pkg;
  localparam int CLK_MHZ = 125;
  localparam int RESET_DONE_CYCLES = 10;
  localparam logic [3:0] RESET_CNT_W_MAX = 4'h9;
  localparam int STRETCH_MS = 50;
  localparam int STRETCH_CYCLES = STRETCH_MS * 1000 * CLK_MHZ;
  localparam int LINK_PULSE_RUN = 7;
  localparam int PACKET_RUN = 3;
  localparam int CMD_START_BIT = 1;
  localparam logic [7:0] CMD_RESET_VAL = 8'h21;
  localparam logic [7:0] IMASK_RESET_VAL = 8'h00;
  localparam logic [7:0] DCFG_RESET_VAL = 8'h00;
  localparam logic [7:0] TCFG_RESET_VAL = 8'h00;

  // network-side events, one-cycle pulses on the bus-side clock
  typedef struct packed {
    logic link_pulse;
    logic link_pulse_reversed;
    logic packet_rx;
    logic packet_reversed;
    logic tx_active;
    logic collision;
  } net_events_s;

  // configuration writes as seen by this block
  typedef struct packed {
    logic cmd_we;
    logic imask_we;
    logic dcfg_we;
    logic tcfg_we;
    logic [7:0] wdata;
  } cfg_write_s;

  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] imask;
    logic [7:0] dcfg;
    logic [7:0] tcfg;
  } cfg_regs_s;

  typedef enum logic [1:0] {
    ST_RESET,
    ST_STOPPED,
    ST_RUNNING
  } run_state_e;
endpackage

// ===== hw/pulse_stretch.sv
// pulse_stretch: holds an output high for a fixed count after the last trigger
// assumes trigger is synchronous to clk_i
`timescale 1ns/1ps
module pulse_stretch #(
  parameter int STRETCH = 6250000
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  input wire logic trig_i,
  output logic out_o
);
  localparam logic [22:0] LOAD = 23'(STRETCH - 1);
  logic [22:0] cnt_r;

  // a new trigger reloads the count so the output covers the last event
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_r <= 23'h0;
      out_o <= 1'b0;
    end else if (en_i) begin
      if (trig_i) begin
        cnt_r <= LOAD;
        out_o <= 1'b1;
      end else if (cnt_r != 23'h0) begin
        cnt_r <= cnt_r - 23'h1;
      end else begin
        out_o <= 1'b0;
      end
    end
  end
endmodule

// ===== sim/host_arbiter.sv
// host_arbiter: behavioural bus arbiter on the host side of the status block
// assumes its request comes from the block and its grant goes back to it
`timescale 1ns/1ps
module host_arbiter (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic req_i,
  input wire integer dly_i,
  output logic grant_o
);
  int wait_r;

  // a slow host is modelled by a larger dly_i; the grant drops at the first falling edge after the request does
  always @(negedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wait_r <= 0;
      grant_o <= 1'b0;
    end else if (!req_i) begin
      wait_r <= 0;
      grant_o <= 1'b0;
    end else if (wait_r >= dly_i) begin
      grant_o <= 1'b1;
    end else begin
      wait_r <= wait_r + 1;
    end
  end
endmodule

// ===== sim/tb_nic_status_top.sv
// tb_nic_status_top: self-checking bench for the reset and status block
// assumes the design body asserts its own rules; inputs change at the falling edge
`timescale 1ns/1ps
module tb_nic_status_top;
  import nic_status_pkg::*;
  localparam int STR = 20;
  logic clk_i, nrst_i, fifo_service_i, bus_grant_i;
  cfg_write_s cfg_wr_i;
  net_events_s net_ev_i;
  cfg_regs_s cfg_o;
  logic reset_done_o, net_enable_o, bus_req_o, dma_go_o, polarity_o, tx_o, col_o;
  int err_count, num_checks, grant_dly;

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // factory test held low throughout: normal behaviour only
  nic_status_top #(.STRETCH(STR)) u_nic_status_top (.clk_i(clk_i), .nrst_i(nrst_i),
    .ce_i(1'b1), .cfg_wr_i(cfg_wr_i), .net_ev_i(net_ev_i), .fifo_service_i(fifo_service_i),
    .bus_grant_i(bus_grant_i), .factory_test_i(1'b0), .cfg_o(cfg_o),
    .reset_done_o(reset_done_o), .net_enable_o(net_enable_o), .bus_request_line_o(bus_req_o),
    .dma_go_o(dma_go_o), .polarity_reversed_flag_o(polarity_o),
    .transmit_activity_indicator_o(tx_o), .collision_o(col_o));
  host_arbiter u_host_arbiter (.clk_i(clk_i), .nrst_i(nrst_i), .req_i(bus_req_o),
    .dly_i(grant_dly), .grant_o(bus_grant_i));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic wr(input int which, input logic [7:0] d);
    cfg_wr_i.wdata = d;
    cfg_wr_i.cmd_we = (which == 0);
    cfg_wr_i.imask_we = (which == 1);
    cfg_wr_i.dcfg_we = (which == 2);
    cfg_wr_i.tcfg_we = (which == 3);
    cyc(1);
    cfg_wr_i = '0;
    // idle cycle so back-to-back calls never rewrite the strobes in one step
    cyc(1);
  endtask

  // kind: 0 link pulse, 1 packet, 2 transmit, 3 collision
  task automatic evt(input int kind, input bit rev);
    net_ev_i.link_pulse = (kind == 0);
    net_ev_i.link_pulse_reversed = (kind == 0) && rev;
    net_ev_i.packet_rx = (kind == 1);
    net_ev_i.packet_reversed = (kind == 1) && rev;
    net_ev_i.tx_active = (kind == 2);
    net_ev_i.collision = (kind == 3);
    cyc(1);
    net_ev_i = '0;
    cyc(1);
  endtask

  task automatic start_net();
    int n;
    wr(0, 8'h01 << CMD_START_BIT);
    n = 0;
    while (net_enable_o !== 1'b1 && n < 6) begin
      cyc(1);
      n++;
    end
    chk(net_enable_o, 1'b1, "net enable after start");
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_reset();
    nrst_i = 1'b0;
    #1;
    chk(cfg_o, {8'h21, 24'h0}, "reset values");
    cyc(9);
    nrst_i = 1'b1;
    cyc(10);
    chk(reset_done_o, 1'b1, "reset done in 10 cycles");
    evt(2, 1'b0);
    cyc(3);
    chk({net_enable_o, tx_o}, 2'b00, "no traffic before start");
    $display("test reset done");
  endtask

  task automatic test_cfg();
    start_net();
    wr(1, 8'h5a);
    wr(2, 8'h3c);
    wr(3, 8'h06);
    cyc(1);
    chk(cfg_o, {8'h01 << CMD_START_BIT, 24'h5a3c06}, "written config");
    wr(0, 8'h00);
    cyc(2);
    chk(net_enable_o, 1'b0, "net stopped by start clear");
    start_net();
    nrst_i = 1'b0;
    #1;
    chk(cfg_o, {8'h21, 24'h0}, "mid-run reset at once");
    chk(net_enable_o, 1'b0, "net stopped by reset");
    cyc(2);
    nrst_i = 1'b1;
    cyc(11);
    start_net();
    $display("test cfg done");
  endtask

  task automatic test_bus();
    int n;
    for (int d = 0; d < 5; d += 4) begin
      grant_dly = d;
      fifo_service_i = 1'b1;
      cyc(2);
      chk(bus_req_o, 1'b1, "bus request raised");
      n = 0;
      while (dma_go_o !== 1'b1 && n < 14) begin
        if (bus_grant_i !== 1'b1) chk(dma_go_o, 1'b0, "dma before grant");
        cyc(1);
        n++;
      end
      chk(dma_go_o, 1'b1, "dma after grant");
      fifo_service_i = 1'b0;
      cyc(3);
      chk({bus_req_o, dma_go_o}, 2'b00, "request released");
      cyc(4);
    end
    $display("test bus done");
  endtask

  task automatic test_pol();
    for (int k = 0; k < 2; k++) begin
      evt(k, 1'b0);
      repeat (k ? 2 : 6) evt(k, 1'b1);
      cyc(3);
      chk(polarity_o, 1'b0, "polarity one short");
      evt(k, 1'b1);
      cyc(3);
      chk(polarity_o, 1'b1, "polarity reversed run");
      evt(k, 1'b0);
      cyc(3);
      chk(polarity_o, 1'b0, "polarity cleared");
    end
    $display("test polarity done");
  endtask

  task automatic test_stretch();
    for (int k = 2; k < 4; k++) begin
      evt(k, 1'b0);
      chk(k == 2 ? tx_o : col_o, 1'b1, "indicator on");
      cyc(8);
      evt(k, 1'b0);
      // output holds STR cycles from the retrigger edge: last high, then first low
      cyc(STR - 2);
      chk(k == 2 ? tx_o : col_o, 1'b1, "indicator restarted");
      cyc(1);
      chk(k == 2 ? tx_o : col_o, 1'b0, "indicator off");
    end
    $display("test stretch done");
  endtask

  // ****************************************
  // run control
  // ****************************************
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #40000;
    err_count++;
    close_out();
  end

  initial begin
    nrst_i = 1'b0;
    fifo_service_i = 1'b0;
    cfg_wr_i = '0;
    net_ev_i = '0;
    grant_dly = 0;
    cyc(1);
    test_reset();
    test_cfg();
    test_bus();
    test_pol();
    test_stretch();
    close_out();
  end
endmodule
